// *** pkg/rdgs_pkg.sv ***
// Constants shared by the receive DMA group select block
package rdgs_pkg;
	// Register byte addresses
	localparam logic [31:0] ADDR_HASH_ADDR_WIN = 32'h0000_0000;
	localparam logic [31:0] ADDR_HASH_DATA_WIN = 32'h0000_0008;
	localparam logic [31:0] ADDR_SEED          = 32'h0004_0060;
	localparam logic [31:0] ADDR_CTRL          = 32'h0004_0100;
	localparam logic [31:0] ADDR_AD_INDEX      = 32'h0004_0110;
	localparam logic [31:0] ADDR_AD_WR_LO      = 32'h0004_0114;
	localparam logic [31:0] ADDR_AD_WR_HI      = 32'h0004_0118;
	localparam logic [31:0] ADDR_AD_RD_LO      = 32'h0004_011C;
	localparam logic [31:0] ADDR_AD_RD_HI      = 32'h0004_0120;
	localparam logic [31:0] ADDR_STATUS        = 32'h0004_0124;
	// Reset values
	localparam logic [31:0] SEED_RESET         = 32'h0000_0000;
	localparam logic [1:0]  CTRL_RESET         = 2'h0;
	// Control bits
	localparam int CTRL_ERR_PREF_BIT           = 0;
	localparam int CTRL_TCAM_DIS_BIT           = 1;
	// Associated data layout
	localparam int AD_W                        = 42;
	localparam int AD_CHK_MSB                  = 41;
	localparam int AD_CHK_LSB                  = 26;
	localparam int AD_PAR_MSB                  = 29;
	localparam int AD_ECC_EN_BIT               = 13;
	localparam int AD_DISC_BIT                 = 12;
	localparam int AD_TRES_MSB                 = 11;
	localparam int AD_TRES_LSB                 = 10;
	localparam int AD_TBL_MSB                  = 9;
	localparam int AD_TBL_LSB                  = 7;
	localparam int AD_OFF_MSB                  = 6;
	localparam int AD_OFF_LSB                  = 2;
	localparam int AD_AGE_BIT                  = 0;
	localparam int AD_HI_W                     = AD_W - 32;
	// Widths
	localparam int TBL_W                       = 3;
	localparam int OFF_W                       = 5;
	localparam int CLS_W                       = 5;
	localparam int KEY_W                       = 104;
	localparam int SYN_W                       = 16;
	localparam int HASH_IDX_W                  = 4;
	// Class range using flow hashing
	localparam logic [CLS_W-1:0] CLS_FLOW_LO   = 5'h04;
	localparam logic [CLS_W-1:0] CLS_FLOW_HI   = 5'h0F;
	// Hash polynomial
	localparam logic [31:0] CRC32C_POLY        = 32'h1EDC_6F41;
	// AHB transfer type
	localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
endpackage

// *** core/rdgs_assoc_mem.sv ***
// Associated-data memory: registered read ports, one software write, one age clear
`timescale 1ns/1ps
module rdgs_assoc_mem #(
	parameter int DEPTH = 256,
	parameter int W     = 42,
	parameter int AW    = 8
) (
	input  wire logic          clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic [W-1:0]  wr_mask,
	input  wire logic          clr_en,
	input  wire logic [AW-1:0] clr_addr,
	input  wire logic [AW-1:0] rd_addr_a,
	output logic      [W-1:0]  rd_data_a,
	input  wire logic [AW-1:0] rd_addr_b,
	output logic      [W-1:0]  rd_data_b
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
		end
		// Lookup clear is issued last so it wins over a same-entry write
		if (clr_en) begin
			mem[clr_addr][0] <= 1'b0;
		end
		rd_data_a <= mem[rd_addr_a];
		rd_data_b <= mem[rd_addr_b];
	end
endmodule

// *** core/rdgs_core.sv ***
// Receive DMA group select: per-packet decision logic with AHB-Lite registers
//
// Behaviour
// [RULE1] TCAM miss continues to flow hash with the layer-2 table.
// [RULE2] TCAM match location indexes associated-data memory.
// [RULE3] Associated data: check 41:26, table 9:7, offset 6:2.
// [RULE4] Drop flag bit 12 discards the packet, other fields ignored.
// [RULE5] Result action 11:10 selects table override and offset use.
// [RULE6] Matching lookup clears age bit 0; software writes to it ignored.
// [RULE7] IPv4 ECC error: layer-2 table, offset zero, stop.
// [RULE8] IPv6 ignores ECC enable; check bits are parity.
// [RULE9] Parity bits 29:26 are even parity over byte groups of 25:0.
// [RULE10] Syndrome over data 25:1, two zeros, key 103:0.
// [RULE11] Early stop reports all-zero user information.
// [RULE12] CRC-32C flow hash; low 4 bits index the group table.
// [RULE13] Seed used as programmed, no zeros appended after the key.
// [RULE14] Non-promiscuous: packets without MAC match are dropped.
// [RULE15] Promiscuous: unmatched packets go to the port default channel.
// [RULE16] VLAN soft error: MAC group entry zero is used.
// [RULE17] TCAM error picks MAC or VLAN default; any error flagged to DMA.
// [RULE18] Untagged uses MAC table; tagged uses VLAN table when preferred.
// [RULE19] No class match: layer-2 table, offset zero, stop.
// [RULE20] Class 4-15 discard drops; no TCAM needed goes straight to hash.
// [RULE21] Continued flow: offset zero outside class 4-15, else hash 3:0.
// [RULE22] Checksum and CRC errors do not affect the decision.
// [RULE23] Software writes class zero into invalid TCAM entries.
// [RULE24] Lowest matching TCAM location wins.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module rdgs_core
	import rdgs_pkg::*;
#(
	parameter int ENTRIES = 256,
	parameter int LOC_W   = 8,
	parameter int FLOW_W  = 64
) (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	// AHB-Lite slave
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic                           hresp,
	output logic [31:0]                    hrdata,
	// Packet from MAC match and parser
	input  wire logic                      pkt_valid,
	input  wire logic                      mac_match,
	input  wire logic                      promisc,
	input  wire logic                      vlan_tagged,
	input  wire logic [rdgs_pkg::TBL_W-1:0] mac_tbl,
	input  wire logic [rdgs_pkg::TBL_W-1:0] vlan_tbl,
	input  wire logic                      vlan_preference,
	input  wire logic                      vlan_soft_err,
	input  wire logic                      class_match,
	input  wire logic [rdgs_pkg::CLS_W-1:0] class_code,
	input  wire logic                      class_disc,
	input  wire logic                      class_tcam_req,
	input  wire logic                      is_ipv6,
	input  wire logic [ENTRIES-1:0]        tcam_match_vec,
	input  wire logic                      tcam_hw_err,
	input  wire logic [rdgs_pkg::KEY_W-1:0] tcam_key,
	input  wire logic [FLOW_W-1:0]         flow_key,
	// Decision to receive DMA
	output logic                           dec_valid,
	output logic                           dec_drop,
	output logic                           dec_port_default,
	output logic [rdgs_pkg::TBL_W-1:0]     dec_tbl,
	output logic [rdgs_pkg::OFF_W-1:0]     dec_offset,
	output logic                           dec_usr_zero,
	output logic                           dec_hw_err,
	output logic                           dec_tcam_hit
);
	import rdgs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Lowest set bit wins  see [RULE24]
	function automatic logic [LOC_W-1:0] low_index(input logic [ENTRIES-1:0] v);
		logic [LOC_W-1:0] r;
		r = '0;
		for (int i = ENTRIES - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = LOC_W'(i);
			end
		end
		return r;
	endfunction

	// Hamming-style syndrome over {data 25:1, 2'b00, key}  see [RULE10]
	function automatic logic [SYN_W-1:0] ecc_syn(input logic [AD_W-1:0] ad,
		input logic [KEY_W-1:0] key);
		logic [130:0]     v;
		logic [SYN_W-1:0] s;
		v = {ad[25:1], 2'b00, key};
		s = '0;
		for (int i = 0; i < 131; i++) begin
			if (v[i]) begin
				s = s ^ SYN_W'(i + 1);
			end
		end
		return s;
	endfunction

	// Even parity per byte group  see [RULE9]
	function automatic logic par_bad(input logic [AD_W-1:0] ad);
		logic [3:0] p;
		p = {^ad[25:24], ^ad[23:16], ^ad[15:8], ^ad[7:0]};
		return p != ad[AD_PAR_MSB:AD_CHK_LSB];
	endfunction

	// MSB-first CRC-32C from the programmed seed, no zero flush  see [RULE12] [RULE13]
	function automatic logic [31:0] crc32c(input logic [31:0] seed, input logic [FLOW_W-1:0] k);
		logic [31:0] c;
		c = seed;
		for (int i = FLOW_W - 1; i >= 0; i--) begin
			c = (c[31] ^ k[i]) ? ((c << 1) ^ CRC32C_POLY) : (c << 1);
		end
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: writes zero-wait, reads one wait state for a registered hrdata

	logic [31:0]          seed, next_seed;
	logic [1:0]           ctrl, next_ctrl;
	logic [LOC_W-1:0]     ad_index, next_ad_index;
	logic [31:0]          ad_wr_lo, next_ad_wr_lo;
	logic [31:0]          status, next_status;
	logic [31:0]          bus_addr, next_bus_addr;
	logic                 wr_pend, next_wr_pend;
	logic                 rd_pend, next_rd_pend;
	logic                 next_hreadyout;
	logic [31:0]          next_hrdata;
	logic                 ad_wr_en;
	logic [AD_W-1:0]      ad_rd;
	logic [AD_W-1:0]      ad_lk;
	logic                 accept;

	assign accept = hsel && htrans[1] && hready;

	always_comb begin
		next_bus_addr  = accept ? haddr : bus_addr;
		next_wr_pend   = accept && hwrite;
		next_rd_pend   = accept && !hwrite;
		next_hreadyout = !(accept && !hwrite);
		next_seed      = seed;
		next_ctrl      = ctrl;
		next_ad_index  = ad_index;
		next_ad_wr_lo  = ad_wr_lo;
		ad_wr_en       = 1'b0;
		if (wr_pend) begin
			unique case (bus_addr)
				ADDR_SEED:     next_seed     = hwdata;
				ADDR_CTRL:     next_ctrl     = hwdata[1:0];
				ADDR_AD_INDEX: next_ad_index = hwdata[LOC_W-1:0];
				ADDR_AD_WR_LO: next_ad_wr_lo = hwdata;
				ADDR_AD_WR_HI: ad_wr_en      = 1'b1;
				default:       ;
			endcase
		end
		next_hrdata = hrdata;
		if (rd_pend) begin
			unique case (bus_addr)
				ADDR_SEED:     next_hrdata = seed;
				ADDR_CTRL:     next_hrdata = {30'h0000_0000, ctrl};
				ADDR_AD_INDEX: next_hrdata = 32'(ad_index);
				ADDR_AD_WR_LO: next_hrdata = ad_wr_lo;
				ADDR_AD_RD_LO: next_hrdata = ad_rd[31:0];
				ADDR_AD_RD_HI: next_hrdata = 32'(ad_rd[AD_W-1:32]);
				ADDR_STATUS:   next_hrdata = status;
				default:       next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			seed      <= SEED_RESET;
			ctrl      <= CTRL_RESET;
			ad_index  <= '0;
			ad_wr_lo  <= 32'h0000_0000;
			bus_addr  <= 32'h0000_0000;
			wr_pend   <= 1'b0;
			rd_pend   <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
		end else begin
			seed      <= next_seed;
			ctrl      <= next_ctrl;
			ad_index  <= next_ad_index;
			ad_wr_lo  <= next_ad_wr_lo;
			bus_addr  <= next_bus_addr;
			wr_pend   <= next_wr_pend;
			rd_pend   <= next_rd_pend;
			hreadyout <= next_hreadyout;
			hresp     <= 1'b0;
			hrdata    <= next_hrdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Associated data memory

	logic [LOC_W-1:0] p_loc;
	logic             p_valid;
	logic             p_hit;

	rdgs_assoc_mem #(
		.DEPTH (ENTRIES),
		.W     (AD_W),
		.AW    (LOC_W)
	) u_mem (
		.clk       (clk),
		.wr_en     (ad_wr_en),
		.wr_addr   (ad_index),
		// Written age value is ignored; a new entry starts clear so its parity is defined
		.wr_data   ({hwdata[AD_HI_W-1:0], ad_wr_lo[31:1], 1'b0}), // see [RULE6]
		.wr_mask   ({AD_W{1'b1}}),
		.clr_en    (p_valid && p_hit),                          // see [RULE6]
		.clr_addr  (p_loc),
		.rd_addr_a (low_index(tcam_match_vec)),                 // see [RULE2] [RULE24]
		.rd_data_a (ad_lk),
		.rd_addr_b (ad_index),
		.rd_data_b (ad_rd)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Packet capture, aligned with the memory read

	logic             p_mac_match, p_promisc, p_tagged, p_vpref, p_vlan_err;
	logic             p_cls_match, p_cls_disc, p_tcam_req, p_ipv6, p_tcam_err;
	logic [TBL_W-1:0] p_mac_tbl, p_vlan_tbl;
	logic [CLS_W-1:0] p_cls;
	logic [KEY_W-1:0] p_key;
	logic [FLOW_W-1:0] p_flow;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			p_valid <= 1'b0;
		end else begin
			p_valid <= pkt_valid;
		end
		p_loc       <= low_index(tcam_match_vec);
		p_hit       <= |tcam_match_vec && !ctrl[CTRL_TCAM_DIS_BIT];
		p_mac_match <= mac_match;
		p_promisc   <= promisc;
		p_tagged    <= vlan_tagged;
		p_vpref     <= vlan_preference;
		p_vlan_err  <= vlan_soft_err;
		p_cls_match <= class_match;
		p_cls_disc  <= class_disc;
		p_tcam_req  <= class_tcam_req;
		p_ipv6      <= is_ipv6;
		p_tcam_err  <= tcam_hw_err;
		p_mac_tbl   <= mac_tbl;
		p_vlan_tbl  <= vlan_tbl;
		p_cls       <= class_code;
		p_key       <= tcam_key;
		p_flow      <= flow_key;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decision

	logic             next_drop, next_dflt, next_usr_zero, next_err;
	logic [TBL_W-1:0] next_tbl, l2_tbl;
	logic [OFF_W-1:0] next_off;
	logic [31:0]      hash;
	logic             cls_mid, ad_bad, ecc_mode;

	// Checksum and CRC errors have no input here by intent  see [RULE22]
	always_comb begin
		hash     = crc32c(seed, p_flow);                                      // see [RULE12]
		cls_mid  = (p_cls >= CLS_FLOW_LO) && (p_cls <= CLS_FLOW_HI);
		ecc_mode = ad_lk[AD_ECC_EN_BIT] && !p_ipv6;                           // see [RULE8]
		ad_bad   = ecc_mode ? (ecc_syn(ad_lk, p_key) != ad_lk[AD_CHK_MSB:AD_CHK_LSB])
			: par_bad(ad_lk);                                                 // see [RULE9]
		// Layer-2 table choice  see [RULE18]
		l2_tbl   = (p_tagged && p_vpref) ? p_vlan_tbl : p_mac_tbl;
		next_drop     = 1'b0;
		next_dflt     = 1'b0;
		next_err      = 1'b0;
		next_usr_zero = 1'b1;
		next_tbl      = l2_tbl;
		next_off      = '0;
		if (!p_mac_match) begin
			next_dflt = p_promisc;                                            // see [RULE15]
			next_drop = !p_promisc;                                           // see [RULE14]
		end else if (p_tagged && p_vlan_err) begin
			next_tbl = p_mac_tbl;                                             // see [RULE16]
			next_err = 1'b1;                                                  // see [RULE17]
		end else if (!p_cls_match) begin
			next_tbl = l2_tbl;                                                // see [RULE19]
		end else if (cls_mid && p_cls_disc) begin
			next_drop = 1'b1;                                                 // see [RULE20]
		end else if ((cls_mid && !p_tcam_req) || !p_hit) begin
			// Straight to flow hashing  see [RULE1] [RULE20]
			if (cls_mid) begin
				next_off      = OFF_W'(hash[HASH_IDX_W-1:0]);               // see [RULE21]
				next_usr_zero = 1'b0;
			end
		end else if (p_tcam_err) begin
			next_tbl = ctrl[CTRL_ERR_PREF_BIT] ? l2_tbl : p_mac_tbl;          // see [RULE17]
			next_err = 1'b1;
		end else if (ad_bad) begin
			next_tbl = l2_tbl;                                                // see [RULE7]
			next_err = 1'b1;                                                  // see [RULE17]
		end else if (ad_lk[AD_DISC_BIT]) begin
			next_drop = 1'b1;                                                 // see [RULE4]
		end else begin
			// Result action decode  see [RULE3] [RULE5]
			if (ad_lk[AD_TRES_MSB]) begin
				next_tbl = ad_lk[AD_TBL_MSB:AD_TBL_LSB];
			end
			if (ad_lk[AD_TRES_LSB]) begin
				next_off = ad_lk[AD_OFF_MSB:AD_OFF_LSB];
			end else if (cls_mid) begin
				next_off      = OFF_W'(hash[HASH_IDX_W-1:0]);               // see [RULE21]
				next_usr_zero = 1'b0;
			end
		end
		// Drops carry no table  see [RULE4]
		if (next_drop) begin
			next_tbl = '0;
			next_off = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			dec_valid        <= 1'b0;
			dec_drop         <= 1'b0;
			dec_port_default <= 1'b0;
			dec_tbl          <= '0;
			dec_offset       <= '0;
			dec_usr_zero     <= 1'b0;
			dec_hw_err       <= 1'b0;
			dec_tcam_hit     <= 1'b0;
			status           <= 32'h0000_0000;
		end else begin
			dec_valid <= p_valid;
			if (p_valid) begin
				dec_drop         <= next_drop;
				dec_port_default <= next_dflt;
				dec_tbl          <= next_tbl;
				dec_offset       <= next_off;
				dec_usr_zero     <= next_usr_zero;                            // see [RULE11]
				dec_hw_err       <= next_err;
				dec_tcam_hit     <= p_hit;
				status <= {19'h00000, p_hit, next_err, next_usr_zero, next_dflt,
					next_drop, next_tbl, next_off};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_nomac;
		pkt_valid && !mac_match;
	endsequence

	sequence s_mid_class;
		pkt_valid && mac_match && !(vlan_tagged && vlan_soft_err) && class_match
			&& class_code >= CLS_FLOW_LO && class_code <= CLS_FLOW_HI;
	endsequence

	chk_latency_two: assert property (pkt_valid |-> ##2 dec_valid)
		else $error("decision not two cycles after packet");
	chk_nomac_drop: assert property (s_nomac and !promisc |-> ##2 dec_drop && !dec_port_default)
		else $error("unmatched packet not dropped"); // see [RULE14]
	chk_promisc_dflt: assert property (s_nomac and promisc |-> ##2 dec_port_default && !dec_drop)
		else $error("promiscuous packet not sent to port default"); // see [RULE15]
	chk_class_disc: assert property (s_mid_class and class_disc |-> ##2 dec_drop)
		else $error("class discard not honoured"); // see [RULE20]
	chk_noclass_zero: assert property (pkt_valid && mac_match && !vlan_tagged && !class_match
		|-> ##2 dec_offset == 5'h00 && dec_tbl == $past(mac_tbl, 2) && dec_usr_zero)
		else $error("no class match decision wrong"); // see [RULE19]
	chk_flow_offset: assert property (s_mid_class and !class_disc and !class_tcam_req
		|-> ##2 !dec_usr_zero && dec_offset < 5'h10)
		else $error("flow hash offset out of range"); // see [RULE21]
	chk_vlan_err: assert property (pkt_valid && mac_match && vlan_tagged && vlan_soft_err
		|-> ##2 dec_hw_err && dec_tbl == $past(mac_tbl, 2) && dec_offset == 5'h00)
		else $error("VLAN error default wrong"); // see [RULE16]
	chk_drop_clean: assert property (dec_valid && dec_drop |-> dec_tbl == 3'h0
		&& dec_offset == 5'h00 && !dec_port_default)
		else $error("dropped packet carries a selection"); // see [RULE4]
	chk_ad_drop: assert property (p_valid && p_mac_match && p_cls_match && p_hit && !p_tcam_err
		&& !ad_bad && ad_lk[AD_DISC_BIT] && !(cls_mid && (p_cls_disc || !p_tcam_req))
		&& !(p_tagged && p_vlan_err) |=> dec_drop)
		else $error("associated-data discard ignored"); // see [RULE4]
	chk_age_clear: assert property (p_valid && p_hit |=> ##1 u_mem.mem[$past(p_loc, 2)][0] == 1'b0)
		else $error("age bit not cleared on match"); // see [RULE6]
endmodule

// *** bench/rdgs_dma_sink.sv ***
// Receive DMA side model: takes each decision and tallies error completions
`timescale 1ns/1ps
module rdgs_dma_sink (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        dec_valid,
	input  wire logic        dec_hw_err,
	output logic      [15:0] seen,
	output logic      [15:0] err_seen
);
	// Error completion status is recorded per packet that carries the flag
	always_ff @(posedge clk) begin
		if (!nrst) begin
			seen     <= 16'h0000;
			err_seen <= 16'h0000;
		end else if (dec_valid === 1'b1) begin
			seen     <= seen + 16'h0001;
			err_seen <= err_seen + {15'h0000, dec_hw_err === 1'b1};
		end
	end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench: register access over AHB-Lite and packet decisions
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
	$display("Error %s expected %h seen %h", nm, exp, got); end end
module tb_top;
	import rdgs_pkg::*;
	logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, pkt_valid = 0, mac_match = 0, promisc = 0;
	logic vlan_tagged = 0, vlan_preference = 0, vlan_soft_err = 0, class_match = 0;
	logic class_disc = 0, class_tcam_req = 0, is_ipv6 = 0, tcam_hw_err = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2, mac_tbl = 3'h2, vlan_tbl = 3'h6, dec_tbl;
	logic [4:0] class_code = 0, dec_offset;
	logic [255:0] tcam_match_vec = 0;
	logic [103:0] tcam_key = 0;
	logic [63:0] flow_key = 64'h0123_4567_89AB_CDEF;
	logic hreadyout, hresp, dec_valid, dec_drop, dec_port_default, dec_usr_zero, dec_hw_err;
	logic dec_tcam_hit;
	logic [15:0] seen, err_seen;
	logic [31:0] rdat, hv;
	int fails = 0, total_checks = 0, npk = 0;
	localparam logic [12:0] ALL = 13'h1FFF;

	always #50 clk = ~clk;

	rdgs_core u_rdgs_core (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .pkt_valid, .mac_match, .promisc,
		.vlan_tagged, .mac_tbl, .vlan_tbl, .vlan_preference, .vlan_soft_err, .class_match,
		.class_code, .class_disc, .class_tcam_req, .is_ipv6, .tcam_match_vec, .tcam_hw_err,
		.tcam_key, .flow_key, .dec_valid, .dec_drop, .dec_port_default, .dec_tbl, .dec_offset,
		.dec_usr_zero, .dec_hw_err, .dec_tcam_hit);
	rdgs_dma_sink u_rdgs_dma_sink (.clk, .nrst, .dec_valid, .dec_hw_err, .seen, .err_seen);

	////////////////////////////////////////////////////////////////////////////////
	// Single word transfer; waits on hready in both phases
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rdat = hrdata;
	endtask

	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK("hrdata", e, rdat)
		`CHK("hresp", 1'b0, hresp)
	endtask

	// Entry with table 5, offset 9, even parity over 25:0 unless corrupted
	function automatic logic [41:0] mk(logic [1:0] t, logic ecc, logic dsc, logic bad);
		logic [41:0] d;
		d = {16'h0000, 12'h000, ecc, dsc, t, 3'h5, 5'h09, 2'b00};
		d[29:26] = {^d[25:24], ^d[23:16], ^d[15:8], ^d[7:0] ^ bad};
		return d;
	endfunction

	task automatic adw(input logic [7:0] i, input logic [41:0] d);
		xfer(1'b1, ADDR_AD_INDEX, {24'h0, i});
		xfer(1'b1, ADDR_AD_WR_LO, d[31:0]);
		xfer(1'b1, ADDR_AD_WR_HI, {22'h0, d[41:32]});
	endtask

	function automatic logic [31:0] h1(logic [31:0] s, logic [63:0] k);
		for (int i = 63; i >= 0; i--) s = {s[30:0], 1'b0} ^ ((s[31] ^ k[i]) ? CRC32C_POLY : 32'h0);
		return s;
	endfunction

	task automatic pkt(input logic [10:0] f, input logic [4:0] cc, input logic [255:0] v);
		{mac_match, promisc, vlan_tagged, vlan_preference, vlan_soft_err, class_match,
			class_disc, class_tcam_req, is_ipv6, tcam_hw_err} <= f[9:0];
		class_code     <= cc;
		tcam_match_vec <= v;
		pkt_valid      <= 1'b1;
		npk++;
		@(posedge clk);
		pkt_valid <= 1'b0;
		// Let the previous packet's decision pulse drop first
		#1;
		for (int n = 0; n < 5 && dec_valid !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		`CHK("dec_valid", 1'b1, dec_valid)
	endtask

	task automatic dec(input logic [12:0] e, input logic [12:0] m);
		`CHK("decision", e & m, {dec_drop, dec_port_default, dec_tbl, dec_offset,
			dec_usr_zero, dec_hw_err, dec_tcam_hit} & m)
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		report_and_stop;
	end

	initial begin
		logic [255:0] b3, b4, b7;
		b3 = 256'h1 << 3; // Entry 3 is matched once before it is programmed, on a path that ignores its data
		b4 = 256'h1 << 4;
		b7 = 256'h1 << 7;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rc(ADDR_SEED, SEED_RESET);
		rc(ADDR_CTRL, 32'h0);
		xfer(1'b1, ADDR_HASH_DATA_WIN, 32'hFFFF_FFFF);
		rc(ADDR_HASH_DATA_WIN, 32'h0);
		rc(ADDR_SEED + 32'h4, 32'h0);
		xfer(1'b1, ADDR_SEED, 32'h1234_5678);
		rc(ADDR_SEED, 32'h1234_5678);
		hv = h1(32'h1234_5678, flow_key);
		pkt(11'h004, 5'h05, 0); dec({1'b1, 1'b0, 3'h0, 5'h00, 1'b1, 2'b00}, ALL);
		pkt(11'h104, 5'h05, 0); dec(13'h0800, 13'h0800);
		pkt(11'h3FC, 5'h05, 0); dec({2'b00, 3'h2, 5'h00, 3'b110}, ALL);
		pkt(11'h3C8, 5'h05, 0); dec({2'b00, 3'h6, 5'h00, 3'b100}, ALL);
		pkt(11'h280, 5'h05, 0); dec({2'b00, 3'h2, 5'h00, 3'b100}, ALL);
		pkt(11'h21C, 5'h05, 0); dec(13'h1004, 13'h1804);
		pkt(11'h3D0, 5'h05, b3); dec({2'b00, 3'h6, 1'b0, hv[3:0], 3'b000}, 13'h1FFE);
		pkt(11'h214, 5'h02, 0); dec({2'b00, 3'h2, 5'h00, 3'b100}, ALL);
		adw(8'h07, mk(2'h0, 1'b0, 1'b1, 1'b0));
		for (int t = 0; t < 4; t++) begin
			// Age bit written high must not stick
			adw(8'h03, mk(t[1:0], 1'b0, 1'b0, 1'b0) | 42'h1);
			pkt(11'h3D4, 5'h05, b3 | b7);
			dec({2'b00, t[1] ? 3'h5 : 3'h6, t[0] ? 5'h09 : {1'b0, hv[3:0]}, t[0], 2'b01},
				ALL);
		end
		pkt(11'h3D4, 5'h05, b7); dec({1'b1, 12'h004}, 13'h1FFE);
		xfer(1'b1, ADDR_AD_INDEX, 32'h3);
		repeat (2) @(posedge clk);
		rc(ADDR_AD_RD_LO, 32'(mk(2'h3, 1'b0, 1'b0, 1'b0)));
		rc(ADDR_AD_RD_HI, 32'h0);
		adw(8'h04, mk(2'h3, 1'b0, 1'b0, 1'b1));
		pkt(11'h214, 5'h02, b4); dec({2'b00, 3'h2, 5'h00, 3'b110}, 13'h1FFE);
		adw(8'h04, mk(2'h3, 1'b1, 1'b0, 1'b0));
		pkt(11'h214, 5'h02, b4); dec({2'b00, 3'h2, 5'h00, 3'b110}, 13'h1FFE);
		pkt(11'h216, 5'h02, b4); dec({2'b00, 3'h5, 5'h09, 3'b101}, ALL);
		pkt(11'h2D5, 5'h05, b3); dec(13'h0202, 13'h0702);
		xfer(1'b1, ADDR_CTRL, 32'h1);
		rc(ADDR_CTRL, 32'h1);
		pkt(11'h2D5, 5'h05, b3); dec(13'h0602, 13'h0702);
		rc(ADDR_STATUS, 32'h0000_1CC0);
		@(posedge clk);
		`CHK("sink count", npk[15:0], seen)
		`CHK("sink errors", 16'h0005, err_seen)
		report_and_stop;
	end
endmodule
